// *** udma_crc_pkg.sv ***
// package for the ultra dma crc checker: register map, fields, codes, carriers
// assumes a single 250 MHz clock domain and 32-bit apb
`default_nettype none
package udma_crc_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [11:0] CTRL_OFS    = 12'h000;
  localparam logic [11:0] STATUS_OFS  = 12'h004;
  localparam logic [11:0] ERROR_OFS   = 12'h008;
  localparam logic [11:0] SENSE_OFS   = 12'h00C;
  localparam logic [11:0] CRC_OFS     = 12'h010;
  localparam logic [11:0] HOSTCRC_OFS = 12'h014;
  localparam logic [11:0] COUNT_OFS   = 12'h018;
  // ----------------------------------------
  // control fields
  // ----------------------------------------
  localparam int CTRL_ULTRA_BIT   = 0;
  localparam int CTRL_CMDCLS_LSB  = 1;
  localparam int CTRL_NEWCMD_BIT  = 3;
  localparam int CTRL_WORDS_LSB   = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // ----------------------------------------
  // error and sense fields
  // ----------------------------------------
  localparam int ERR_INTERFACE_CRC_ERROR_FLAG_BIT  = 7;
  localparam int ERR_ABORTED_COMMAND_FLAG_BIT  = 2;
  localparam int ERR_CHK_BIT   = 0;
  localparam logic [15:0] CRC_SEED        = 16'h4ABA;
  localparam logic [3:0]  SENSE_KEY_ABORT = 4'hB;
  localparam logic [3:0]  SENSE_KEY_HW    = 4'h4;
  localparam logic [7:0]  ASC_CRC         = 8'h08;
  localparam logic [7:0]  ASCQ_CRC        = 8'h03;
  // ----------------------------------------
  // command classes
  // ----------------------------------------
  typedef enum logic [1:0] {
    CMD_DMA      = 2'h0,
    CMD_SENSE    = 2'h1,
    CMD_PACKET   = 2'h2,
    CMD_OTHER    = 2'h3
  } cmd_class_t;
  // ----------------------------------------
  // link carrier
  // ----------------------------------------
  typedef struct packed {
    logic        burst_start;
    logic        word_strobe;
    logic        term_acked;
    logic        dmack_neg;
    logic [15:0] data;
  } link_in_t;
  typedef struct packed {
    logic        paddr_ok;
    logic [31:0] rdata;
  } rd_t;
endpackage
`default_nettype wire

// *** udma_crc_check.sv ***
// ultra dma crc engine and checker with apb registers
// assumes link events are already synchronous on SYS_CLK, one-cycle pulses except the TERM_ACKED level
`default_nettype none
// Notes on behaviour
// RULE1: own sixteen-bit crc engine and register
// RULE2: fresh crc for each burst
// RULE3: seed 4ABA at burst start
// RULE4: update crc on each data strobe
// RULE5: ignore strobe after termination acknowledge
// RULE6: host drives crc with dmack negation
// RULE7: compare host crc, record mismatch
// RULE8: matching later burst keeps error
// RULE9: only first error reported
// RULE10: dma commands set interface_crc_error_flag and abort
// RULE11: host reissues command after crc error
// RULE12: request sense error: check, key 0B
// RULE13: request sense keeps original sense data
// RULE14: packet error: key 04, asc 08/03
// RULE15: checking only in ultra dma mode
// RULE16: host slows ultra mode on errors
// RULE17: device ends data-out burst when done
// RULE18: surplus words enter crc, are discarded
// RULE19: polynomial x16 + x12 + x5 + 1
// RULE20: equals serial shift, d0 first
// RULE21: sixteen xor terms, edge-triggered register
// RULE22: crc bit n on data line n
// RULE23: capture host crc at dmack negation
// RULE24: new command clears recorded error
module udma_crc_check
  import udma_crc_pkg::*;
(
  input  wire logic        SYS_CLK,      // 250 MHz clock
  input  wire logic        RESET_N,      // sync reset, active low
  input  wire logic        PSEL,         // apb select
  input  wire logic        PENABLE,      // apb access phase
  input  wire logic        PWRITE,       // apb direction
  input  wire logic [11:0] PADDR,        // apb byte address
  input  wire logic [31:0] PWDATA,       // apb write data
  output logic      [31:0] PRDATA,       // apb read data
  output logic             PREADY,       // apb ready
  output logic             PSLVERR,      // apb error
  input  wire logic        BURST_START,  // burst begins, pulse
  input  wire logic        WORD_STROBE,  // strobe edge carrying data, pulse
  input  wire logic        TERM_ACKED,   // termination acknowledged, level
  input  wire logic        DMACK_NEG,    // dmack negating edge, pulse
  input  wire logic [15:0] DATA_IN,      // bus data lines
  output logic             STORE_WORD,   // word to be stored, pulse
  output logic      [15:0] STORE_DATA,   // data for storage
  output logic             BURST_STOP,   // request termination, level
  output logic             CHECK_DONE    // compare finished, pulse
);

  // ----------------------------------------
  // parallel crc
  // ----------------------------------------
  function automatic logic [15:0] crc_step(input logic [15:0] cur, input logic [15:0] d);
    logic [16:1] f;
    logic [15:0] n;
    f     = '0;
    n     = '0;
    f[1]  = d[0] ^ cur[15];
    f[2]  = d[1] ^ cur[14];
    f[3]  = d[2] ^ cur[13];
    f[4]  = d[3] ^ cur[12];
    f[5]  = d[4] ^ cur[11] ^ f[1];
    f[6]  = d[5] ^ cur[10] ^ f[2];
    f[7]  = d[6] ^ cur[9] ^ f[3];
    f[8]  = d[7] ^ cur[8] ^ f[4];
    f[9]  = d[8] ^ cur[7] ^ f[5];
    f[10] = d[9] ^ cur[6] ^ f[6];
    f[11] = d[10] ^ cur[5] ^ f[7];
    f[12] = d[11] ^ cur[4] ^ f[1] ^ f[8];
    f[13] = d[12] ^ cur[3] ^ f[2] ^ f[9];
    f[14] = d[13] ^ cur[2] ^ f[3] ^ f[10];
    f[15] = d[14] ^ cur[1] ^ f[4] ^ f[11];
    f[16] = d[15] ^ cur[0] ^ f[5] ^ f[12];
    n[0]  = f[16];
    n[1]  = f[15];
    n[2]  = f[14];
    n[3]  = f[13];
    n[4]  = f[12];
    n[5]  = f[11] ^ f[16];
    n[6]  = f[10] ^ f[15];
    n[7]  = f[9] ^ f[14];
    n[8]  = f[8] ^ f[13];
    n[9]  = f[7] ^ f[12];
    n[10] = f[6] ^ f[11];
    n[11] = f[5] ^ f[10];
    n[12] = f[4] ^ f[9] ^ f[16];
    n[13] = f[3] ^ f[8] ^ f[15];
    n[14] = f[2] ^ f[7] ^ f[14];
    n[15] = f[1] ^ f[6] ^ f[13];
    return n;
  endfunction

  // command class field of a control word
  function automatic cmd_class_t class_of(input logic [31:0] w);
    return cmd_class_t'(w[CTRL_CMDCLS_LSB +: 2]);
  endfunction

  // true while the command still wants words stored
  function automatic logic more_wanted(input logic [15:0] cnt, input logic [31:0] ctrl);
    return cnt != ctrl[CTRL_WORDS_LSB +: 16];
  endfunction

  link_in_t    lk;
  logic [31:0] ctrl_q;
  logic [15:0] crc_current_value;
  logic [15:0] crc_next_value;
  logic [15:0] host_crc_q;
  logic        in_burst_q;
  logic        err_held_q;
  logic [7:0]  err_reg_q;
  logic        check_condition_flag;
  logic [3:0]  sense_key_q;
  logic [7:0]  asc_q;
  logic [7:0]  ascq_q;
  logic [15:0] words_q;
  logic        ultra;
  cmd_class_t  cmd_class;
  logic        new_cmd;
  logic        data_word;
  logic        mismatch;
  logic        wr_en;
  logic        rd_en;
  rd_t         rd;

  assign lk             = '{BURST_START, WORD_STROBE, TERM_ACKED, DMACK_NEG, DATA_IN};
  assign ultra          = ctrl_q[CTRL_ULTRA_BIT];
  assign cmd_class      = class_of(ctrl_q);
  assign wr_en          = PSEL && PENABLE && PWRITE;
  assign rd_en          = PSEL && PENABLE && !PWRITE;
  assign new_cmd        = wr_en && PADDR == CTRL_OFS && PWDATA[CTRL_NEWCMD_BIT];
  assign data_word      = lk.word_strobe && !lk.term_acked && in_burst_q;    // RULE5
  assign crc_next_value = crc_step(crc_current_value, lk.data);             // RULE19 RULE20 RULE21
  assign mismatch       = host_crc_q != crc_current_value;

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
      ctrl_q <= CTRL_RESET;
    else if (wr_en && PADDR == CTRL_OFS)
      ctrl_q <= PWDATA & ~(32'h1 << CTRL_NEWCMD_BIT);
  end

  // ----------------------------------------
  // burst tracking and crc register
  // ----------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
      in_burst_q <= 1'b0;
    else if (lk.burst_start && ultra)                                       // RULE15
      in_burst_q <= 1'b1;
    else if (lk.dmack_neg)
      in_burst_q <= 1'b0;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
      crc_current_value <= CRC_SEED;
    else if (lk.burst_start)
      crc_current_value <= CRC_SEED;                                        // RULE1 RULE2 RULE3
    else if (data_word)
      crc_current_value <= crc_next_value;                                  // RULE4 RULE18
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
      host_crc_q <= 16'h0000;
    else if (lk.dmack_neg && in_burst_q)
      host_crc_q <= lk.data;                                                // RULE6 RULE22 RULE23
  end

  // ----------------------------------------
  // word count, storage and stop request
  // ----------------------------------------
  logic more_words;

  // surplus words past the expected count still feed the crc
  assign more_words = more_wanted(words_q, ctrl_q);

  // count stops at the expected number
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
      words_q <= 16'h0000;
    else if (new_cmd)
      words_q <= 16'h0000;
    else if (data_word && more_words)
      words_q <= words_q + 16'h0001;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
      STORE_WORD <= 1'b0;
    else
      STORE_WORD <= data_word && more_words;                                // RULE18
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
      STORE_DATA <= 16'h0000;
    else
      STORE_DATA <= lk.data;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
      BURST_STOP <= 1'b0;
    else
      BURST_STOP <= in_burst_q && !more_words;                              // RULE17
  end

  // ----------------------------------------
  // compare
  // ----------------------------------------
  logic cmp_q;
  logic capture;
  logic keep_sense;

  // a capture in the same cycle as a new command wins over the clear
  assign capture    = cmp_q && mismatch && !err_held_q && ultra;            // RULE7 RULE8 RULE9 RULE15
  // sense key and asc survive a new request sense command
  assign keep_sense = class_of(PWDATA) == CMD_SENSE;

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
      cmp_q <= 1'b0;
    else
      cmp_q <= lk.dmack_neg && in_burst_q;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
      CHECK_DONE <= 1'b0;
    else
      CHECK_DONE <= cmp_q;
  end

  // ----------------------------------------
  // error record
  // ----------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
      err_held_q <= 1'b0;
    else if (capture)
      err_held_q <= 1'b1;                                                   // RULE9
    else if (new_cmd)
      err_held_q <= 1'b0;                                                   // RULE24
  end

  // class 3 reports only the interface crc bit
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
      err_reg_q <= 8'h00;
    else if (capture)
    begin
      if (cmd_class == CMD_DMA || cmd_class == CMD_OTHER)
        err_reg_q[ERR_INTERFACE_CRC_ERROR_FLAG_BIT] <= 1'b1;                                    // RULE10
      if (cmd_class == CMD_DMA)
        err_reg_q[ERR_ABORTED_COMMAND_FLAG_BIT] <= 1'b1;                                    // RULE10
    end
    else if (new_cmd)
      err_reg_q <= 8'h00;                                                   // RULE24
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
      check_condition_flag <= 1'b0;
    else if (capture && (cmd_class == CMD_SENSE || cmd_class == CMD_PACKET))
      check_condition_flag <= 1'b1;                                         // RULE12 RULE14
    else if (new_cmd && !capture)
      check_condition_flag <= 1'b0;                                         // RULE24
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
      sense_key_q <= 4'h0;
    else if (capture && cmd_class == CMD_SENSE)
      sense_key_q <= SENSE_KEY_ABORT;                                       // RULE12
    else if (capture && cmd_class == CMD_PACKET)
      sense_key_q <= SENSE_KEY_HW;                                          // RULE14
    else if (new_cmd && !keep_sense && !capture)
      sense_key_q <= 4'h0;                                                  // RULE24
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
    begin
      asc_q  <= 8'h00;
      ascq_q <= 8'h00;
    end
    else if (capture && cmd_class == CMD_PACKET)
    begin
      asc_q  <= ASC_CRC;                                                    // RULE14
      ascq_q <= ASCQ_CRC;
    end
    else if (new_cmd && !keep_sense && !capture)
    begin
      asc_q  <= 8'h00;                                                      // RULE13 RULE24
      ascq_q <= 8'h00;
    end
  end

  // ----------------------------------------
  // apb read decode
  // ----------------------------------------
  always_comb
  begin
    rd = '{1'b1, 32'h0000_0000};
    unique case (PADDR)
      CTRL_OFS:    rd.rdata = ctrl_q;
      STATUS_OFS:  rd.rdata = {29'h0, BURST_STOP, err_held_q, in_burst_q};
      ERROR_OFS:   rd.rdata = {23'h0, check_condition_flag, err_reg_q};
      SENSE_OFS:   rd.rdata = {12'h0, sense_key_q, asc_q, ascq_q};
      CRC_OFS:     rd.rdata = {16'h0, crc_current_value};
      HOSTCRC_OFS: rd.rdata = {16'h0, host_crc_q};
      COUNT_OFS:   rd.rdata = {16'h0, words_q};
      default:     rd.paddr_ok = 1'b0;
    endcase
  end

  // ----------------------------------------
  // apb response
  // ----------------------------------------
  logic setup;

  assign setup = PSEL && !PENABLE;

  // ready one cycle after setup, so the access cycle never waits
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
      PREADY <= 1'b0;
    else
      PREADY <= setup;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
      PSLVERR <= 1'b0;
    else
      PSLVERR <= setup && !rd.paddr_ok;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESET_N)
      PRDATA <= 32'h0000_0000;
    else if (setup && !PWRITE)
      PRDATA <= rd.rdata;
    else
      PRDATA <= 32'h0000_0000;
  end

endmodule
`default_nettype wire

// *** udma_crc_check_monitor.sv ***
// checker: apb handshake, burst end timing, word storage
// assumes a bind onto the crc block ports
`default_nettype none
module udma_crc_check_monitor (
  input wire logic        SYS_CLK,     // clock
  input wire logic        RESET_N,     // reset
  input wire logic        PSEL,        // select
  input wire logic        PENABLE,     // access
  input wire logic [31:0] PRDATA,      // read data
  input wire logic        PREADY,      // ready
  input wire logic        PSLVERR,     // error
  input wire logic        WORD_STROBE, // strobe
  input wire logic        TERM_ACKED,  // term ack
  input wire logic        DMACK_NEG,   // burst end
  input wire logic [15:0] DATA_IN,     // data
  input wire logic        STORE_WORD,  // store
  input wire logic [15:0] STORE_DATA,  // stored word
  input wire logic        BURST_STOP,  // stop
  input wire logic        CHECK_DONE   // done
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  ready_after_setup_a: assert property (setup_s |=> PREADY) else $error("ready late");
  ready_in_access_a: assert property (PREADY |-> PSEL && PENABLE) else $error("stray ready");
  error_with_ready_a: assert property (PSLVERR |-> PREADY) else $error("stray error");
  idle_data_zero_a: assert property (!PREADY |-> PRDATA == 32'h0) else $error("data idle");
  done_delay_a: assert property (CHECK_DONE |-> $past(DMACK_NEG, 2)) else $error("done timing");
  store_cause_a: assert property (STORE_WORD |-> $past(WORD_STROBE && !TERM_ACKED))
    else $error("store cause");
  store_copy_a: assert property (STORE_WORD |-> STORE_DATA == $past(DATA_IN)) else $error("store data");
  surplus_drop_a: assert property (BURST_STOP && WORD_STROBE |=> !STORE_WORD)
    else $error("surplus stored");
endmodule
`default_nettype wire

// *** udma_host_model.sv ***
// host partner: drives ultra dma bursts, keeps its own serial crc
// assumes link fields are sampled on the rising clock edge
`default_nettype none
module udma_host_model
  import udma_crc_pkg::*;
(
  input  wire logic clk,  // system clock
  output var link_in_t link  // events and data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] rnd = 32'h0000_F3D0;
  logic [15:0] crc_q = 16'h0;
  initial link = '0;
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // bit 0 shifted in first
  function automatic logic [15:0] step(logic [15:0] c, logic [15:0] d);
    for (int i = 0; i < 16; i++)
      c = {c[14:0], 1'b0} ^ ((d[i] ^ c[15]) ? 16'h1021 : 16'h0);
    return c;
  endfunction
  task automatic burst(input int n, input logic bad);
    @(posedge clk);
    link.burst_start <= 1'b1;
    crc_q = CRC_SEED;
    @(posedge clk);
    link.burst_start <= 1'b0;
    repeat (n)
    begin
      rnd = lfsr(rnd);
      crc_q = step(crc_q, rnd[15:0]);
      link.word_strobe <= 1'b1;
      link.data <= rnd[15:0];
      @(posedge clk);
      link.word_strobe <= 1'b0;
      link.data <= ~rnd[15:0];
      @(posedge clk);
    end
    link.term_acked <= 1'b1;
    link.word_strobe <= 1'b1;
    @(posedge clk);
    link.word_strobe <= 1'b0;
    link.dmack_neg <= 1'b1;
    link.data <= crc_q ^ {15'h0, bad};
    @(posedge clk);
    link.dmack_neg <= 1'b0;
    link.term_acked <= 1'b0;
    link.data <= ~link.data;
    repeat (3) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// *** udma_crc_check_bench.sv ***
// bench for the crc block: apb master, host model, random burst data
// assumes package, host model and monitor compiled first
`default_nettype none
module udma_crc_check_bench
  import udma_crc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        SYS_CLK = 1'b0, RESET_N = 1'b0;
  logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h0;
  logic [31:0] PWDATA = 32'h0, PRDATA, r;
  logic        PREADY, PSLVERR, STORE_WORD, BURST_STOP, CHECK_DONE, e;
  logic [15:0] STORE_DATA, hc;
  link_in_t    link;
  int          miscompares = 0, n_checks = 0, stores = 0, dones = 0, s;
  assign hc = udma_host_model_i.crc_q;
  always #2 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK)
  begin
    stores <= stores + int'(STORE_WORD === 1'b1);
    dones <= dones + int'(CHECK_DONE === 1'b1);
  end
  udma_crc_check udma_crc_check_i (
    .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .BURST_START(link.burst_start), .WORD_STROBE(link.word_strobe), .TERM_ACKED(link.term_acked),
    .DMACK_NEG(link.dmack_neg), .DATA_IN(link.data), .STORE_WORD(STORE_WORD),
    .STORE_DATA(STORE_DATA), .BURST_STOP(BURST_STOP), .CHECK_DONE(CHECK_DONE));
  udma_host_model udma_host_model_i (.clk(SYS_CLK), .link(link));
  task automatic close_out();
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h, want %h", $time, seen, want);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do
      @(posedge SYS_CLK);
    while (PREADY !== 1'b1);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] want);
    apb(1'b0, a, 32'h0);
    chk(r & m, want);
  endtask
  // new command with mode, class and expected words
  task automatic cmd(input logic u, input cmd_class_t c, input logic [15:0] n);
    apb(1'b1, CTRL_OFS, {n, 12'h0, 1'b1, c, u});
  endtask
  task automatic bst(input int n, input logic bad);
    udma_host_model_i.burst(n, bad);
  endtask
  initial
  begin
    repeat (4000) @(posedge SYS_CLK);
    miscompares++;
    close_out();
  end
  initial
  begin
    repeat (6) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    rdc(CTRL_OFS, 32'hFFFF_FFFF, CTRL_RESET);
    rdc(CRC_OFS, 32'hFFFF, {16'h0, CRC_SEED});
    apb(1'b0, 12'h0FC, 32'h0);
    chk({31'h0, e}, 32'h1);
    cmd(1'b1, CMD_DMA, 16'h4);
    bst(4, 1'b0);
    rdc(CRC_OFS, 32'hFFFF, {16'h0, hc});
    rdc(HOSTCRC_OFS, 32'hFFFF, {16'h0, hc});
    rdc(ERROR_OFS, 32'h84, 32'h0);
    bst(3, 1'b1);
    rdc(ERROR_OFS, 32'h84, 32'h84);
    bst(2, 1'b0);
    rdc(ERROR_OFS, 32'h84, 32'h84);
    cmd(1'b1, CMD_DMA, 16'h4);
    rdc(ERROR_OFS, 32'h84, 32'h0);
    cmd(1'b1, CMD_PACKET, 16'h8);
    rdc(ERROR_OFS, 32'hFFFF_FFFF, 32'h0);
    bst(2, 1'b1);
    rdc(SENSE_OFS, 32'hF_FFFF, {12'h0, SENSE_KEY_HW, ASC_CRC, ASCQ_CRC});
    rdc(ERROR_OFS, 32'h84, 32'h0);
    chk({31'h0, |(r & 32'h101)}, 32'h1);
    cmd(1'b1, CMD_SENSE, 16'h8);
    bst(2, 1'b1);
    rdc(SENSE_OFS, 32'hF_FFFF, {12'h0, SENSE_KEY_ABORT, ASC_CRC, ASCQ_CRC});
    cmd(1'b0, CMD_DMA, 16'h8);
    bst(2, 1'b1);
    rdc(ERROR_OFS, 32'hFFFF_FFFF, 32'h0);
    cmd(1'b1, CMD_DMA, 16'h3);
    s = stores;
    bst(5, 1'b0);
    chk(stores - s, 32'h3);
    chk(dones, 32'h6);
    close_out();
  end
endmodule
bind udma_crc_check udma_crc_check_monitor udma_crc_check_monitor_i (
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .WORD_STROBE(WORD_STROBE), .TERM_ACKED(TERM_ACKED),
  .DMACK_NEG(DMACK_NEG), .DATA_IN(DATA_IN), .STORE_WORD(STORE_WORD), .STORE_DATA(STORE_DATA),
  .BURST_STOP(BURST_STOP), .CHECK_DONE(CHECK_DONE));
`default_nettype wire
